// ### design/intc_defines.vh
// Constants for the interrupt and wake-up controller: register
// addresses, field positions, reset values and vector layout.
// Assumes an 8-bit special-register address space.
`ifndef INTC_DEFINES_VH
`define INTC_DEFINES_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_PORT_WAKE 8'h96
`define ADDR_IE_MAIN 8'hA8
`define ADDR_IE_SECOND 8'hA9
`define ADDR_PRIO_LOW_MAIN 8'hB8
`define ADDR_PRIO_HIGH_MAIN 8'hB9
`define ADDR_PRIO_LOW_SECOND 8'hBA
`define ADDR_PRIO_HIGH_SECOND 8'hBB
`define ADDR_FLAGS_A 8'hC0
`define ADDR_FLAGS_B 8'hC1
`define ADDR_FLAGS_C 8'hC2
`define ADDR_SERVICE 8'hC3

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define REG_RESET 8'h00
`define IE_MAIN_MASK 8'hBF
`define PRIO_MAIN_MASK 8'h3F
`define RDATA_IDLE 8'h00

// ----------------------------------------
// Main enable fields
// ----------------------------------------
`define IE_GLOBAL 7
`define IE_SERIAL 4
`define IE_TIMER1 3
`define IE_PIN0 0
`define IE_PIN1 2

// ----------------------------------------
// Second enable fields
// ----------------------------------------
`define IE2_PIN2 2

// ----------------------------------------
// Flag bit positions
// ----------------------------------------
`define FLAG_PIN0 0
`define FLAG_T0 1
`define FLAG_PIN1 2
`define FLAG_T1 3
`define FLAG_RX 4
`define FLAG_TX 5
`define FLAG_T2 6
`define FLAG_T2EXT 7
`define FLAG_T3 8
`define FLAG_PORT 9
`define FLAG_PIN2 10
`define FLAG_CONV 11
`define FLAG_TWI 12
`define FLAG_PGEN 13
`define FLAG_PDET 14
`define FLAG_CMP 15
`define FLAG_PWM 16
`define FLAG_W 17
`define FLAGS_RESET 17'h00000

// ----------------------------------------
// Vector slots
// ----------------------------------------
`define SLOTS 15
`define SLOT_TOP 14
`define SLOT_EMU 6
`define VEC_BASE 16'h0003
`define LVL_NONE 2'h0

`endif

// ### design/interrupt_wakeup_controller.v
// Four-level priority interrupt controller with Idle/Stop wake-up.
// Assumes synchronous event pulses, pins sampled on i_sys_clk and
// a CPU that acknowledges vectors and signals service return.
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`include "intc_defines.vh"

module interrupt_wakeup_controller (
  input wire i_sys_clk,          // System clock, 25 MHz
  input wire i_rst,              // Sync reset, active high
  input wire i_ce,               // Clock enable, freezes state
  input wire [7:0] i_addr,       // Register address
  input wire [7:0] i_wdata,      // Register write data
  input wire i_wr,               // Write strobe
  input wire i_rd,               // Read strobe
  output reg [7:0] o_rdata,      // Read data, cycle after i_rd
  input wire i_timer0_ovf,       // Timer 0 overflow pulse
  input wire i_timer1_ovf,       // Timer 1 overflow pulse
  input wire i_serial_rx,        // Receive complete pulse
  input wire i_serial_tx,        // Transmit complete pulse
  input wire i_timer2_ovf,       // Timer 2 overflow pulse
  input wire i_timer2_ext,       // Timer 2 external pulse
  input wire i_timer3_ovf,       // Timer 3 overflow pulse
  input wire i_conv_done,        // Converter done pulse
  input wire i_two_wire,         // Two-wire master pulse
  input wire i_pulse_gen,        // Pulse generator pulse
  input wire i_pulse_det,        // Pulse detector pulse
  input wire i_comparator,       // Comparator pulse
  input wire i_pulse_width,      // Pulse width unit pulse
  input wire i_ext_pin0,         // External pin zero level
  input wire i_ext_pin1,         // External pin one level
  input wire i_ext_pin2,         // External pin two level
  input wire [7:0] i_port_one,   // Port-one pin levels
  input wire i_cpu_idle,         // CPU in Idle mode
  input wire i_cpu_stop,         // CPU in Stop mode
  input wire i_cpu_ack,          // CPU takes the offered vector
  input wire i_cpu_return,       // Service routine finished
  output reg o_irq_req,          // Vector offered to CPU
  output reg [15:0] o_vector,    // Offered vector address
  output reg [1:0] o_irq_lvl,    // Level of offered vector
  output reg o_wake              // Wake request to power control
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] port_wake_r;
  reg [7:0] ie_main_r;
  reg [7:0] ie_second_r;
  reg [5:0] prio_low_main_r;
  reg [5:0] prio_high_main_r;
  reg [7:0] prio_low_second_r;
  reg [7:0] prio_high_second_r;
  reg [`FLAG_W-1:0] flags_r;
  reg [`FLAG_W-1:0] flags_nxt;
  reg [2:0] pins_prev_r;
  reg [7:0] port_prev_r;
  reg [7:0] rdata_nxt;

  wire wr_port_wake;
  wire wr_ie_main;
  wire wr_ie_second;
  wire wr_pl_main;
  wire wr_ph_main;
  wire wr_pl_second;
  wire wr_ph_second;
  wire [`FLAG_W-1:0] clr_mask;
  wire [`FLAG_W-1:0] set_mask;
  wire [2:0] pins_now;
  wire [2:0] pins_fall;
  wire [7:0] port_change;

  wire [`SLOTS-1:0] slot_req;
  wire [`SLOTS-1:0] slot_en;
  wire [`SLOTS-1:0] slot_pend;
  wire [`SLOTS-1:0] lvl_hi;
  wire [`SLOTS-1:0] lvl_lo;
  wire global_en;

  reg best_ok;
  reg [1:0] best_lvl;
  reg [3:0] best_idx;
  integer i;

  wire stk_active;
  wire [1:0] stk_lvl;
  wire [3:0] stk_mask;
  wire accept;
  wire offer_nxt;
  wire idle_wake;
  wire stop_wake;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  assign wr_port_wake = i_wr && (i_addr == `ADDR_PORT_WAKE);
  assign wr_ie_main = i_wr && (i_addr == `ADDR_IE_MAIN);
  assign wr_ie_second = i_wr && (i_addr == `ADDR_IE_SECOND);
  assign wr_pl_main = i_wr && (i_addr == `ADDR_PRIO_LOW_MAIN);
  assign wr_ph_main = i_wr && (i_addr == `ADDR_PRIO_HIGH_MAIN);
  assign wr_pl_second = i_wr && (i_addr == `ADDR_PRIO_LOW_SECOND);
  assign wr_ph_second = i_wr && (i_addr == `ADDR_PRIO_HIGH_SECOND);

  // Flags clear by writing ones; each byte clears only at its own address
  assign clr_mask[7:0] =
    (i_wr && (i_addr == `ADDR_FLAGS_A)) ? i_wdata : 8'h00;
  assign clr_mask[15:8] =
    (i_wr && (i_addr == `ADDR_FLAGS_B)) ? i_wdata : 8'h00;
  assign clr_mask[16] =
    i_wr && (i_addr == `ADDR_FLAGS_C) && i_wdata[0];

  // ----------------------------------------
  // Pin event detection
  // ----------------------------------------
  assign pins_now = {i_ext_pin2, i_ext_pin1, i_ext_pin0};
  // Edge-only: a pin held low flags once, then stays quiet
  assign pins_fall = pins_prev_r & ~pins_now;
  // Disabled port pins never flag, so they cannot wake either
  assign port_change = (i_port_one ^ port_prev_r) & port_wake_r;

  // ----------------------------------------
  // Flag capture, independent of enables except the port wake mask
  // ----------------------------------------
  assign set_mask[`FLAG_PIN0] = pins_fall[0];
  assign set_mask[`FLAG_T0] = i_timer0_ovf;
  assign set_mask[`FLAG_PIN1] = pins_fall[1];
  assign set_mask[`FLAG_T1] = i_timer1_ovf;
  assign set_mask[`FLAG_RX] = i_serial_rx;
  assign set_mask[`FLAG_TX] = i_serial_tx;
  assign set_mask[`FLAG_T2] = i_timer2_ovf;
  assign set_mask[`FLAG_T2EXT] = i_timer2_ext;
  assign set_mask[`FLAG_T3] = i_timer3_ovf;
  assign set_mask[`FLAG_PORT] = |port_change;
  assign set_mask[`FLAG_PIN2] = pins_fall[2];
  assign set_mask[`FLAG_CONV] = i_conv_done;
  assign set_mask[`FLAG_TWI] = i_two_wire;
  assign set_mask[`FLAG_PGEN] = i_pulse_gen;
  assign set_mask[`FLAG_PDET] = i_pulse_det;
  assign set_mask[`FLAG_CMP] = i_comparator;
  assign set_mask[`FLAG_PWM] = i_pulse_width;

  // Service never clears a flag; software writes ones
  // Set beats clear so an event in the clearing cycle survives
  always @* begin
    flags_nxt = (flags_r & ~clr_mask) | set_mask;
  end

  // ----------------------------------------
  // Slot requests, enables and levels
  // ----------------------------------------
  // Reserved slot carries no request, enable or level
  assign slot_req = {
    flags_r[`FLAG_PWM],
    flags_r[`FLAG_CMP],
    flags_r[`FLAG_PGEN] | flags_r[`FLAG_PDET],
    flags_r[`FLAG_TWI],
    flags_r[`FLAG_CONV],
    flags_r[`FLAG_PIN2],
    flags_r[`FLAG_PORT],
    flags_r[`FLAG_T3],
    1'b0,
    flags_r[`FLAG_T2] | flags_r[`FLAG_T2EXT],
    flags_r[`FLAG_RX] | flags_r[`FLAG_TX],
    flags_r[`FLAG_T1],
    flags_r[`FLAG_PIN1],
    flags_r[`FLAG_T0],
    flags_r[`FLAG_PIN0]
  };

  // Main register bits 5..0 serve slots 5..0, second serves 14..7
  assign slot_en = {ie_second_r, 1'b0, ie_main_r[5:0]};
  assign global_en = ie_main_r[`IE_GLOBAL];
  assign slot_pend = slot_req & slot_en & {`SLOTS{global_en}};

  assign lvl_lo = {prio_low_second_r, 1'b0, prio_low_main_r};
  assign lvl_hi = {prio_high_second_r, 1'b0, prio_high_main_r};

  // ----------------------------------------
  // Arbitration
  // ----------------------------------------
  // Level codes compare as {high, low}, so 11 outranks 00
  // Descending scan with >= lets the lowest slot win a tie
  always @* begin
    best_ok = 1'b0;
    best_lvl = `LVL_NONE;
    best_idx = 4'h0;
    for (i = `SLOT_TOP; i >= 0; i = i - 1) begin
      if (slot_pend[i] && (!best_ok || {lvl_hi[i], lvl_lo[i]} >= best_lvl)) begin
        best_ok = 1'b1;
        best_lvl = {lvl_hi[i], lvl_lo[i]};
        best_idx = i[3:0];
      end
    end
  end

  // Offer drops in the accept cycle so one take pushes once
  // Only a strictly higher level may interrupt a running service
  assign offer_nxt = best_ok && (!stk_active || (best_lvl > stk_lvl)) && !accept;
  assign accept = i_cpu_ack && o_irq_req;

  // ----------------------------------------
  // Service level stack
  // ----------------------------------------
  // Push and pop in one cycle: pop drops the old top first
  irq_level_stack u_stack (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_push(accept),
    .i_push_lvl(o_irq_lvl),
    .i_pop(i_cpu_return),
    .o_active(stk_active),
    .o_lvl(stk_lvl),
    .o_mask(stk_mask)
  );

  // ----------------------------------------
  // Wake-up
  // ----------------------------------------
  // Idle wake follows servicing, so it needs the global enable
  assign idle_wake = i_cpu_idle && (|slot_pend);
  // Pin paths ignore the global enable on purpose
  // Port flag already carries the per-pin gate
  assign stop_wake = i_cpu_stop && (
    (flags_r[`FLAG_PIN0] && ie_main_r[`IE_PIN0]) ||
    (flags_r[`FLAG_PIN1] && ie_main_r[`IE_PIN1]) ||
    (flags_r[`FLAG_PIN2] && ie_second_r[`IE2_PIN2]) ||
    flags_r[`FLAG_PORT]);

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Zero outside the answer cycle, so stale data never linger
  always @* begin
    rdata_nxt = `RDATA_IDLE;
    if (i_rd) begin
      case (i_addr)
        `ADDR_PORT_WAKE: rdata_nxt = port_wake_r;
        `ADDR_IE_MAIN: rdata_nxt = ie_main_r;
        `ADDR_IE_SECOND: rdata_nxt = ie_second_r;
        `ADDR_PRIO_LOW_MAIN: rdata_nxt = {2'h0, prio_low_main_r};
        `ADDR_PRIO_HIGH_MAIN: rdata_nxt = {2'h0, prio_high_main_r};
        `ADDR_PRIO_LOW_SECOND: rdata_nxt = prio_low_second_r;
        `ADDR_PRIO_HIGH_SECOND: rdata_nxt = prio_high_second_r;
        `ADDR_FLAGS_A: rdata_nxt = flags_r[7:0];
        `ADDR_FLAGS_B: rdata_nxt = flags_r[15:8];
        `ADDR_FLAGS_C: rdata_nxt = {7'h00, flags_r[16]};
        `ADDR_SERVICE: rdata_nxt = {stk_active, 1'b0, stk_lvl, stk_mask};
        default: rdata_nxt = `RDATA_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      port_wake_r <= `REG_RESET;
      ie_main_r <= `REG_RESET;
      ie_second_r <= `REG_RESET;
      prio_low_main_r <= 6'h00;
      prio_high_main_r <= 6'h00;
      prio_low_second_r <= `REG_RESET;
      prio_high_second_r <= `REG_RESET;
      o_rdata <= `RDATA_IDLE;
    end else if (i_ce) begin
      if (wr_port_wake)
        port_wake_r <= i_wdata;
      // Reserved bit 6 is never stored and reads 0
      if (wr_ie_main)
        ie_main_r <= i_wdata & `IE_MAIN_MASK;
      if (wr_ie_second)
        ie_second_r <= i_wdata;
      if (wr_pl_main)
        prio_low_main_r <= i_wdata[5:0];
      if (wr_ph_main)
        prio_high_main_r <= i_wdata[5:0];
      if (wr_pl_second)
        prio_low_second_r <= i_wdata;
      if (wr_ph_second)
        prio_high_second_r <= i_wdata;
      o_rdata <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // Flags and pin history
  // ----------------------------------------
  // History resets low so no false falling edge follows reset
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      flags_r <= `FLAGS_RESET;
      pins_prev_r <= 3'h0;
      port_prev_r <= 8'h00;
    end else if (i_ce) begin
      flags_r <= flags_nxt;
      pins_prev_r <= pins_now;
      port_prev_r <= i_port_one;
    end
  end

  // ----------------------------------------
  // CPU offer and wake outputs
  // ----------------------------------------
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_irq_req <= 1'b0;
      o_vector <= `VEC_BASE;
      o_irq_lvl <= `LVL_NONE;
      o_wake <= 1'b0;
    end else if (i_ce) begin
      o_irq_req <= offer_nxt;
      o_vector <= `VEC_BASE + {9'h000, best_idx, 3'h0};
      o_irq_lvl <= best_lvl;
      o_wake <= idle_wake || stop_wake;
    end
  end

endmodule

// ### design/irq_level_stack.v
// In-service level record for nested interrupt service.
// Assumes one push per accepted vector and one pop per return.
`timescale 1ns/100ps
`include "intc_defines.vh"

module irq_level_stack (
  input wire i_sys_clk,        // System clock
  input wire i_rst,            // Sync reset, active high
  input wire i_ce,             // Clock enable
  input wire i_push,           // Vector accepted
  input wire [1:0] i_push_lvl, // Level of accepted vector
  input wire i_pop,            // Service routine returned
  output reg o_active,         // Some level in service
  output reg [1:0] o_lvl,      // Highest level in service
  output wire [3:0] o_mask     // One bit per level in service
);

  reg [3:0] mask_r;
  reg [3:0] mask_nxt;
  reg [3:0] top_hot;
  integer k;

  assign o_mask = mask_r;

  // ----------------------------------------
  // Highest level currently in service
  // ----------------------------------------
  always @* begin
    o_active = 1'b0;
    o_lvl = `LVL_NONE;
    top_hot = 4'h0;
    for (k = 0; k < 4; k = k + 1) begin
      if (mask_r[k]) begin
        o_active = 1'b1;
        o_lvl = k[1:0];
        top_hot = 4'h1 << k;
      end
    end
  end

  // Pop drops only the top, so the pre-empted level resumes
  always @* begin
    mask_nxt = mask_r;
    if (i_pop)
      mask_nxt = mask_nxt & ~top_hot;
    if (i_push)
      mask_nxt = mask_nxt | (4'h1 << i_push_lvl);
  end

  always @(posedge i_sys_clk) begin
    if (i_rst)
      mask_r <= 4'h0;
    else if (i_ce)
      mask_r <= mask_nxt;
  end

endmodule

// ### sim/cpu_model.sv
// CPU side model: takes each offered vector after a short or long wait.
// Assumes the controller's clock and a one-cycle take pulse.
`timescale 1ns/100ps

module cpu_model (
  input wire i_sys_clk,       // System clock
  input wire i_rst,           // Sync reset, active high
  input wire i_en,            // Accept offered vectors
  input wire i_slow,          // Wait three cycles before taking
  input wire i_irq_req,       // Vector offered
  input wire [15:0] i_vector, // Offered vector
  output reg o_ack,           // Take pulse
  output reg [15:0] o_taken   // Vector seen at the accept edge
);
  integer cnt_r;

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_ack <= 1'b0;
      o_taken <= 16'h0000;
      cnt_r <= 0;
    end else if (o_ack) begin
      o_ack <= 1'b0;
      o_taken <= i_vector;
      cnt_r <= 0;
    end else if (i_en && i_irq_req) begin
      // Take only while offered; a slow CPU lets the offer stand
      if (cnt_r >= (i_slow ? 3 : 0)) begin
        o_ack <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1;
      end
    end else begin
      cnt_r <= 0;
    end
  end
endmodule

// ### sim/intc_chk_chk.sv
// Port-level assertions for the interrupt and wake-up controller.
// Assumes the clock enable is high around every read-back and enable write.
`timescale 1ns/100ps

module intc_chk (
  input wire i_sys_clk,       // System clock
  input wire i_rst,           // Sync reset
  input wire [7:0] i_addr,    // Register address
  input wire [7:0] i_wdata,   // Write data
  input wire i_wr,            // Write strobe
  input wire i_rd,            // Read strobe
  input wire [7:0] o_rdata,   // Read data
  input wire i_cpu_idle,      // Idle mode
  input wire i_cpu_stop,      // Stop mode
  input wire i_cpu_ack,       // Vector taken
  input wire o_irq_req,       // Vector offered
  input wire [15:0] o_vector, // Offered vector
  input wire o_wake           // Wake request
);
  // ----------------------------------------
  // Shadow of the main enable register
  // ----------------------------------------
  reg [7:0] ie_sh_r;
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      ie_sh_r <= 8'h00;
    end else if (i_wr && i_addr == 8'hA8) begin
      ie_sh_r <= i_wdata;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence s_wr(a);
    i_wr && i_addr == a;
  endsequence
  sequence s_rd(a);
    i_rd && i_addr == a;
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_VEC_SLOT: assert property (o_irq_req |-> o_vector[2:0] == 3'h3 && o_vector <= 16'h0073)
    else $error("offered vector off the slot grid");
  AST_ICE_SLOT: assert property (o_irq_req |-> o_vector != 16'h0033)
    else $error("reserved slot offered");
  AST_P1_READBACK: assert property (s_wr(8'h96) ##1 s_rd(8'h96) |=> o_rdata == $past(i_wdata, 2))
    else $error("port wake enable readback wrong");
  AST_IE_READBACK: assert property (s_wr(8'hA8) ##1 s_rd(8'hA8) |=> o_rdata == ($past(i_wdata, 2) & 8'hBF))
    else $error("main enable readback wrong");
  AST_GLOBAL_OFF: assert property (!ie_sh_r[7] && !$past(ie_sh_r[7]) |-> !o_irq_req)
    else $error("vector offered with global enable clear");
  AST_ACK_DROP: assert property (i_cpu_ack && o_irq_req |=> !o_irq_req)
    else $error("same vector offered again after take");
  AST_WAKE_MODE: assert property (o_wake |-> $past(i_cpu_idle || i_cpu_stop))
    else $error("wake outside Idle or Stop");
  AST_IDLE_WAKE: assert property (o_irq_req && i_cpu_idle && !$past(i_wr) |=> o_wake)
    else $error("no wake from Idle on enabled request");
endmodule

bind interrupt_wakeup_controller intc_chk u_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cpu_idle(i_cpu_idle),
  .i_cpu_stop(i_cpu_stop), .i_cpu_ack(i_cpu_ack), .o_irq_req(o_irq_req), .o_vector(o_vector), .o_wake(o_wake));

// ### sim/tb_top.sv
// Self-checking bench for the interrupt and wake-up controller.
// Assumes the CPU model takes vectors while enabled.
`timescale 1ns/100ps
`include "intc_defines.vh"

module tb_top;
  reg i_sys_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, idle = 0, stop = 0, ret = 0, en = 0, slow = 0, ce = 1;
  reg [7:0] i_addr = 8'h00, i_wdata = 8'h00, port = 8'h00;
  reg [16:0] ev = 17'h00000;
  wire [7:0] o_rdata;
  wire [15:0] vec, taken;
  wire req, ack, wake;
  wire [1:0] lvl;
  integer err_count = 0, total_checks = 0, cyc = 0, s, i;
  int fb[15] = '{0, 1, 2, 3, 5, 7, 0, 8, 9, 10, 11, 12, 14, 15, 16};
  logic [15:0] tv[4] = '{16'h001B, 16'h0023, 16'h002B, 16'h0063};
  logic [7:0] ta[4] = '{8'hC0, 8'hC0, 8'hC0, 8'hC1};
  logic [7:0] td[4] = '{8'h08, 8'h30, 8'hC0, 8'h60};

  // Pins idle high; an event bit drives its pin low
  interrupt_wakeup_controller uut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_timer0_ovf(ev[1]), .i_timer1_ovf(ev[3]),
    .i_serial_rx(ev[4]), .i_serial_tx(ev[5]), .i_timer2_ovf(ev[6]), .i_timer2_ext(ev[7]), .i_timer3_ovf(ev[8]),
    .i_conv_done(ev[11]), .i_two_wire(ev[12]), .i_pulse_gen(ev[13]), .i_pulse_det(ev[14]),
    .i_comparator(ev[15]), .i_pulse_width(ev[16]), .i_ext_pin0(!ev[0]), .i_ext_pin1(!ev[2]),
    .i_ext_pin2(!ev[10]), .i_port_one(port), .i_cpu_idle(idle), .i_cpu_stop(stop), .i_cpu_ack(ack),
    .i_cpu_return(ret), .o_irq_req(req), .o_vector(vec), .o_irq_lvl(lvl), .o_wake(wake));
  cpu_model cpu (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_en(en), .i_slow(slow), .i_irq_req(req),
    .i_vector(vec), .o_ack(ack), .o_taken(taken));

  initial begin
    forever #20 i_sys_clk = !i_sys_clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check(input [15:0] seen, input [15:0] exp, input string what);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    i_wr <= 1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 0;
    #1;
  endtask
  task rd(input [7:0] a, input [7:0] exp, input string what);
    i_rd <= 1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 0;
    #1 check({8'h00, o_rdata}, {8'h00, exp}, what);
  endtask
  task pulse(input [16:0] m);
    ev <= m & 17'h1FDFF;
    if (m[9]) port <= port ^ 8'h01;
    @(posedge i_sys_clk);
    ev <= 17'h00000;
  endtask
  task give_back;
    ret <= 1;
    @(posedge i_sys_clk);
    ret <= 0;
  endtask
  task wait_n(input integer n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task wait_take(input [15:0] exp);
    for (i = 0; i < 20 && ack !== 1'b1; i = i + 1) wait_n(1);
    wait_n(1);
    check(taken, exp, "vector");
  endtask
  task tally_and_finish;
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count = err_count + 1;
      tally_and_finish;
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 0;
    @(posedge i_sys_clk);
    rd(`ADDR_PORT_WAKE, 8'h00, "wake_en reset");
    rd(`ADDR_IE_MAIN, 8'h00, "ie reset");
    wr(`ADDR_PORT_WAKE, 8'hA5);
    rd(`ADDR_PORT_WAKE, 8'hA5, "wake_en");
    wr(`ADDR_IE_MAIN, 8'h7F);
    rd(`ADDR_IE_MAIN, 8'h3F, "ie");
    ce <= 0;
    wr(`ADDR_PORT_WAKE, 8'h5A);
    ce <= 1;
    rd(8'h00, 8'h00, "unmapped");
    rd(`ADDR_PORT_WAKE, 8'hA5, "wake_en frozen");
    pulse(17'h0000A);
    wait_n(3);
    rd(`ADDR_FLAGS_A, 8'h0A, "flags no enable");
    check({15'h0000, req}, 16'h0000, "req global off");
    wr(`ADDR_FLAGS_A, 8'hFF);
    wr(`ADDR_PORT_WAKE, 8'h01);
    wr(`ADDR_IE_SECOND, 8'hFF);
    wr(`ADDR_IE_MAIN, 8'hBF);
    en <= 1;
    for (s = 0; s < 15; s = s + 1) begin
      if (s != `SLOT_EMU) begin
        slow <= s[0];
        pulse(17'h00001 << fb[s]);
        wait_take(16'h0003 + 16'h0008 * s);
        wr(`ADDR_FLAGS_A, 8'hFF);
        wr(`ADDR_FLAGS_B, 8'hFF);
        wr(`ADDR_FLAGS_C, 8'h01);
        give_back;
      end
    end
    pulse(17'h02058);
    for (s = 0; s < 4; s = s + 1) begin
      wait_take(tv[s]);
      wait_n(3);
      check({15'h0000, req}, 16'h0000, "equal level held");
      wr(ta[s], td[s]);
      give_back;
    end
    wr(`ADDR_PRIO_HIGH_MAIN, 8'h08);
    pulse(17'h00002);
    wait_take(16'h000B);
    rd(`ADDR_SERVICE, 8'h81, "service one");
    pulse(17'h00008);
    wait_take(16'h001B);
    check({14'h0000, lvl}, 16'h0002, "offered level");
    rd(`ADDR_SERVICE, 8'hA5, "service nested");
    wr(`ADDR_FLAGS_A, 8'h08);
    give_back;
    rd(`ADDR_SERVICE, 8'h81, "service restored");
    wr(`ADDR_FLAGS_A, 8'h02);
    give_back;
    rd(`ADDR_SERVICE, 8'h00, "service empty");
    en <= 0;
    wr(`ADDR_PRIO_HIGH_MAIN, 8'h00);
    idle <= 1;
    wr(`ADDR_IE_MAIN, 8'h82);
    pulse(17'h00002);
    wait_n(4);
    check({15'h0000, wake}, 16'h0001, "idle wake");
    idle <= 0;
    stop <= 1;
    wait_n(3);
    check({15'h0000, wake}, 16'h0000, "stop timer");
    wr(`ADDR_IE_MAIN, 8'h01);
    pulse(17'h00001);
    wait_n(3);
    check({15'h0000, wake}, 16'h0001, "stop pin");
    wr(`ADDR_FLAGS_A, 8'hFF);
    wr(`ADDR_PORT_WAKE, 8'h02);
    pulse(17'h00200);
    wait_n(3);
    check({15'h0000, wake}, 16'h0000, "masked port pin");
    port <= port ^ 8'h02;
    wait_n(3);
    check({15'h0000, wake}, 16'h0001, "port wake");
    rd(`ADDR_FLAGS_B, 8'h02, "port flag");
    wr(`ADDR_PRIO_LOW_MAIN, 8'hFF);
    rd(`ADDR_PRIO_LOW_MAIN, 8'h3F, "prio low main");
    wr(`ADDR_PRIO_HIGH_SECOND, 8'hA5);
    rd(`ADDR_PRIO_HIGH_SECOND, 8'hA5, "prio high second");
    tally_and_finish;
  end
endmodule
